// ===== rtl/pmr_phy_regs.v
// Overview of operation
// - control bit 8 selects full duplex
// - control bit 5 picks crossover algorithm
// - bit 4 forces MDI or MDIX
// - bit 2 suppresses far-end fault detection
// - bit 1 stops the transmitter
// - bit 0 turns LEDs off
// - status 14..11 ones, bit 15 zero
// - status 5 shows negotiation done
// - status 4 shows far-end fault
// - status 3 reads constant one
// - status 2 shows link state
// - status 0, 10..6, 1 read zero
// - identifier split over addresses 2, 3
// - advertisement bit 10 offers pause
// - advertisement bits 8..5 offer abilities
// - selector 00001, 12..11 01, 15..13 zero
// - answer own address, known registers only
// - control bit 12 enables negotiation
// - control bit 15 self-clearing soft reset
`timescale 1ns/10ps
`default_nettype none
`include "pmr_map.vh"

module pmr_phy_regs #(
  parameter [4:0]  PHY_ADDR = 5'h01,   // port address, 1 to 3
  parameter [15:0] ID_HI    = 16'h0123, // arbitrary value
  parameter [15:0] ID_LO    = 16'h4567  // arbitrary value
) (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        reset_in,
  // management serial pins
  input  wire        mdc_in,
  input  wire        mdio_in,
  output wire        mdio_out,
  output wire        mdio_oe_n_out,
  // port state from the phy
  input  wire        negotiation_done_in,
  input  wire        far_fault_in,
  input  wire        link_up_in,
  input  wire [15:0] partner_ability_in,
  // port controls
  output wire        soft_reset_out,
  output wire        negotiation_on_out,
  output wire        full_duplex_out,
  output wire        crossover_algorithm_select_out,
  output wire        force_mdi_out,
  output wire        auto_mdix_off_out,
  output wire        far_fault_off_out,
  output wire        tx_off_out,
  output wire        led_off_out,
  // advertised abilities
  output wire        adv_pause_out,
  output wire [3:0]  adv_ability_out
);

  // ==========================================================
  // frame states, one-hot
  localparam [4:0] S_PRE = 5'h01; // preamble hunt
  localparam [4:0] S_HDR = 5'h02; // start, op, addresses
  localparam [4:0] S_TA  = 5'h04; // turnaround
  localparam [4:0] S_RD  = 5'h08; // shift read data out
  localparam [4:0] S_WR  = 5'h10; // shift write data in

  // ==========================================================
  // functions
  // register addresses this port answers
  function pmr_known;
    input [4:0] ra;
    begin
      pmr_known = (ra <= `PMR_REG_PART) ||
                  (ra == `PMR_REG_CDIAG) ||
                  (ra == `PMR_REG_SPEC);
    end
  endfunction

  // ==========================================================
  // synchronisers and frame state
  reg        mdc_s1_q;   // first stage, clock pin
  reg        mdc_s2_q;   // second stage
  reg        mdc_s3_q;   // edge history
  reg        mdio_s1_q;  // first stage, data pin
  reg        mdio_s2_q;  // second stage
  reg [4:0]  state_q;    // frame state
  reg [5:0]  pre_cnt_q;  // consecutive preamble ones
  reg [4:0]  bit_cnt_q;  // bit position within a field
  reg [11:0] hdr_q;      // header bits so far
  reg        rd_op_q;    // current frame is a read
  reg [4:0]  reg_q;      // addressed register
  reg [15:0] rd_sh_q;    // read data shifter
  reg [15:0] wr_sh_q;    // write data shifter
  reg        mdo_q;      // pin data out
  reg        mdo_oe_n_q; // pin enable, low drives
  reg        wr_stb_q;   // one-cycle write commit
  reg [4:0]  wr_reg_q;   // write target
  reg [15:0] wr_dat_q;   // write value

  // ==========================================================
  // register state
  reg        an_on_q;    // negotiation enabled
  reg        fdx_q;      // forced full duplex
  reg        xalg_q;     // crossover algorithm choice
  reg        fmdi_q;     // forced straight mode
  reg        noamdix_q;  // automatic crossover off
  reg        nofef_q;    // far-end fault ignored
  reg        notx_q;     // transmitter off
  reg        noled_q;    // leds off
  reg        pause_q;    // advertise pause
  reg        b9_q;       // spare writable bit
  reg [3:0]  abil_q;     // advertise 100f,100h,10f,10h
  reg        an_dn_q;    // negotiation done, sampled
  reg        fef_q;      // far-end fault, sampled
  reg        link_q;     // link up, sampled
  reg [15:0] part_q;     // partner ability, sampled
  reg        srst_go_q;  // soft reset request pulse

  wire        srst_busy;  // soft reset running
  wire        mdc_rise;   // rising edge of the clock pin
  wire        din;        // sampled data bit
  wire [12:0] hdr_full;   // header with the newest bit
  reg  [15:0] rd_word;    // read data for an address

  assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
  assign din      = mdio_s2_q;
  assign hdr_full = {hdr_q, din};

  // ==========================================================
  // pin synchronisers; only the second stage and the clock's edge history are looked at
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      mdc_s1_q  <= 1'b0;
      mdc_s2_q  <= 1'b0;
      mdc_s3_q  <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q  <= mdc_in;
      mdc_s2_q  <= mdc_s1_q;
      mdc_s3_q  <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  // ==========================================================
  // read data selection
  always @* begin
    case (hdr_full[4:0])
      // control: upper mode bits outside this block read zero
      `PMR_REG_CTRL: begin
        rd_word = {srst_busy, 2'b00, an_on_q, 3'b000, fdx_q, 2'b00,
                   xalg_q, fmdi_q, noamdix_q, nofef_q, notx_q, noled_q};
      end
      // status: constant abilities merged with live state
      `PMR_REG_STAT: begin
        rd_word = `PMR_STAT_CONST |
                  {10'h000, an_dn_q, fef_q, 1'b0, link_q, 2'b00};
      end
      // identifier words
      `PMR_REG_ID_HI: rd_word = ID_HI;
      `PMR_REG_ID_LO: rd_word = ID_LO;
      // advertisement: fixed selector and reserved pattern
      `PMR_REG_ADV: begin
        rd_word = `PMR_ADV_CONST |
                  {5'h00, pause_q, b9_q, abil_q, 5'h00};
      end
      `PMR_REG_PART: rd_word = part_q;
      // diagnostic and special registers answer zero here
      default: rd_word = 16'h0000;
    endcase
  end

  // ==========================================================
  // serial frame engine, acts once per rising pin clock edge
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q    <= S_PRE;
      pre_cnt_q  <= 6'h00;
      bit_cnt_q  <= 5'h00;
      hdr_q      <= 12'h000;
      rd_op_q    <= 1'b0;
      reg_q      <= 5'h00;
      rd_sh_q    <= 16'h0000;
      wr_sh_q    <= 16'h0000;
      mdo_q      <= 1'b1;
      mdo_oe_n_q <= 1'b1;
      wr_stb_q   <= 1'b0;
      wr_reg_q   <= 5'h00;
      wr_dat_q   <= 16'h0000;
    end else begin
      // commit strobe lasts one cycle
      wr_stb_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          // count ones; a zero after enough ones opens a frame
          S_PRE: begin
            if (din) begin
              if (pre_cnt_q != `PMR_PRE_BITS) begin
                pre_cnt_q <= pre_cnt_q + 6'h01;
              end
            end else begin
              if (pre_cnt_q == `PMR_PRE_BITS) begin
                state_q   <= S_HDR;
                bit_cnt_q <= 5'h00;
              end
              pre_cnt_q <= 6'h00;
            end
          end
          // gather start bit, opcode, port and register address
          S_HDR: begin
            hdr_q     <= hdr_full[11:0];
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `PMR_HDR_LAST) begin
              bit_cnt_q <= 5'h00;
              // foreign address or unknown register: stay silent
              if (hdr_full[12] &&
                  ((hdr_full[11:10] == `PMR_OP_RD) ||
                   (hdr_full[11:10] == `PMR_OP_WR)) &&
                  (hdr_full[9:5] == PHY_ADDR) &&
                  pmr_known(hdr_full[4:0])) begin
                state_q <= S_TA;
                rd_op_q <= (hdr_full[11:10] == `PMR_OP_RD);
                reg_q   <= hdr_full[4:0];
                rd_sh_q <= rd_word;
              end else begin
                state_q <= S_PRE;
              end
            end
          end
          // read: drive the turnaround zero; write: skip two bits
          S_TA: begin
            if (rd_op_q) begin
              mdo_q      <= 1'b0;
              mdo_oe_n_q <= 1'b0;
              state_q    <= S_RD;
              bit_cnt_q  <= 5'h00;
            end else if (bit_cnt_q == `PMR_TA_LAST) begin
              state_q   <= S_WR;
              bit_cnt_q <= 5'h00;
            end else begin
              bit_cnt_q <= bit_cnt_q + 5'h01;
            end
          end
          // most significant bit first, release after the last
          S_RD: begin
            if (bit_cnt_q == `PMR_RD_BITS) begin
              mdo_q      <= 1'b1;
              mdo_oe_n_q <= 1'b1;
              state_q    <= S_PRE;
            end else begin
              mdo_q     <= rd_sh_q[15];
              rd_sh_q   <= {rd_sh_q[14:0], 1'b0};
              bit_cnt_q <= bit_cnt_q + 5'h01;
            end
          end
          // collect data; write happens only on a complete word
          S_WR: begin
            wr_sh_q   <= {wr_sh_q[14:0], din};
            bit_cnt_q <= bit_cnt_q + 5'h01;
            if (bit_cnt_q == `PMR_WR_LAST) begin
              wr_stb_q <= 1'b1;
              wr_reg_q <= reg_q;
              wr_dat_q <= {wr_sh_q[14:0], din};
              state_q  <= S_PRE;
            end
          end
          default: begin
            state_q    <= S_PRE;
            mdo_oe_n_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // writable control and advertisement bits
  // soft reset holds them at defaults until it ends, so a write
  // that lands during the reset is lost on purpose
  always @(posedge ref_clk_in) begin
    srst_go_q <= 1'b0;
    if (reset_in || srst_busy) begin
      an_on_q   <= `PMR_AN_ON_RST;
      fdx_q     <= `PMR_FDX_RST;
      xalg_q    <= `PMR_XALG_RST;
      fmdi_q    <= `PMR_FMDI_RST;
      noamdix_q <= `PMR_NOAMDIX_RST;
      nofef_q   <= `PMR_NOFEF_RST;
      notx_q    <= `PMR_NOTX_RST;
      noled_q   <= `PMR_NOLED_RST;
      pause_q   <= `PMR_PAUSE_RST;
      b9_q      <= `PMR_B9_RST;
      abil_q    <= `PMR_ABIL_RST;
    end else if (wr_stb_q) begin
      case (wr_reg_q)
        // control: only the implemented bits take the value
        `PMR_REG_CTRL: begin
          srst_go_q <= wr_dat_q[`PMR_CTL_SRST];
          an_on_q   <= wr_dat_q[`PMR_CTL_AN_ON];
          fdx_q     <= wr_dat_q[`PMR_CTL_FDX];
          xalg_q    <= wr_dat_q[`PMR_CTL_XALG];
          fmdi_q    <= wr_dat_q[`PMR_CTL_FMDI];
          noamdix_q <= wr_dat_q[`PMR_CTL_NOAMDIX];
          nofef_q   <= wr_dat_q[`PMR_CTL_NOFEF];
          notx_q    <= wr_dat_q[`PMR_CTL_NOTX];
          noled_q   <= wr_dat_q[`PMR_CTL_NOLED];
        end
        // advertisement: selector and reserved bits stay fixed
        `PMR_REG_ADV: begin
          pause_q <= wr_dat_q[`PMR_ADV_PAUSE];
          b9_q    <= wr_dat_q[`PMR_ADV_B9];
          abil_q  <= wr_dat_q[`PMR_ADV_ABIL_LSB +: 4];
        end
        // read-only registers drop the write
        default: begin
          an_on_q <= an_on_q;
        end
      endcase
    end
  end

  // ==========================================================
  // live status sampled each cycle; either reset clears it, partner word to PMR_PART_CONST
  always @(posedge ref_clk_in) begin
    if (reset_in || srst_busy) begin
      an_dn_q <= 1'b0;
      fef_q   <= 1'b0;
      link_q  <= 1'b0;
      part_q  <= `PMR_PART_CONST;
    end else begin
      an_dn_q <= negotiation_done_in;
      fef_q   <= far_fault_in & ~nofef_q;
      link_q  <= link_up_in;
      part_q  <= (partner_ability_in & `PMR_PART_MASK) | `PMR_PART_CONST;
    end
  end

  // ==========================================================
  // soft reset timer
  pmr_soft_reset u_srst (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .start_in   (srst_go_q),
    .busy_out   (srst_busy)
  );

  // ==========================================================
  // outputs, all straight from flops
  assign mdio_out                       = mdo_q;
  assign mdio_oe_n_out                  = mdo_oe_n_q;
  assign soft_reset_out                 = srst_busy;
  assign negotiation_on_out             = an_on_q;
  assign full_duplex_out                = fdx_q;
  assign crossover_algorithm_select_out = xalg_q;
  assign force_mdi_out                  = fmdi_q;
  assign auto_mdix_off_out              = noamdix_q;
  assign far_fault_off_out              = nofef_q;
  assign tx_off_out                     = notx_q;
  assign led_off_out                    = noled_q;
  assign adv_pause_out                  = pause_q;
  assign adv_ability_out                = abil_q;

endmodule // pmr_phy_regs

`default_nettype wire

// ===== inc/pmr_map.vh
`ifndef PMR_MAP_VH
`define PMR_MAP_VH

// ==========================================================
// management register addresses
`define PMR_REG_CTRL      5'h00
`define PMR_REG_STAT      5'h01
`define PMR_REG_ID_HI     5'h02
`define PMR_REG_ID_LO     5'h03
`define PMR_REG_ADV       5'h04
`define PMR_REG_PART      5'h05
`define PMR_REG_CDIAG     5'h1D
`define PMR_REG_SPEC      5'h1F

// ==========================================================
// basic control bit positions
`define PMR_CTL_SRST      15
`define PMR_CTL_AN_ON     12
`define PMR_CTL_FDX       8
`define PMR_CTL_XALG      5
`define PMR_CTL_FMDI      4
`define PMR_CTL_NOAMDIX   3
`define PMR_CTL_NOFEF     2
`define PMR_CTL_NOTX      1
`define PMR_CTL_NOLED     0

// basic control reset values
`define PMR_AN_ON_RST     1'h1
`define PMR_FDX_RST       1'h1
`define PMR_XALG_RST      1'h1
`define PMR_FMDI_RST      1'h0
`define PMR_NOAMDIX_RST   1'h0
`define PMR_NOFEF_RST     1'h0
`define PMR_NOTX_RST      1'h0
`define PMR_NOLED_RST     1'h0

// ==========================================================
// status, advertisement and partner constants
`define PMR_STAT_CONST    16'h7808
`define PMR_ADV_PAUSE     10
`define PMR_ADV_B9        9
`define PMR_ADV_ABIL_LSB  5
`define PMR_ADV_CONST     16'h0801
`define PMR_PAUSE_RST     1'h1
`define PMR_B9_RST        1'h0
`define PMR_ABIL_RST      4'hF
`define PMR_PART_MASK     16'h05E0
`define PMR_PART_CONST    16'h0001

// ==========================================================
// serial management frame
`define PMR_PRE_BITS      6'h20
`define PMR_OP_RD         2'h2
`define PMR_OP_WR         2'h1
`define PMR_HDR_LAST      5'h0C
`define PMR_TA_LAST       5'h01
`define PMR_WR_LAST       5'h0F
`define PMR_RD_BITS       5'h10

// ==========================================================
// timing
`define PMR_CLK_PERIOD_NS 40
`define PMR_SRST_TIME_NS  1000
`define PMR_SRST_CYCLES   ((`PMR_SRST_TIME_NS + `PMR_CLK_PERIOD_NS - 1) / `PMR_CLK_PERIOD_NS)

`endif

// ===== rtl/pmr_soft_reset.v
`timescale 1ns/10ps
`default_nettype none
`include "pmr_map.vh"

module pmr_soft_reset (
  // clock and reset
  input  wire ref_clk_in,
  input  wire reset_in,
  // control
  input  wire start_in,
  output wire busy_out
);

  // ==========================================================
  // constants
  localparam integer SRST_CYC = `PMR_SRST_CYCLES;
  localparam [7:0]   SRST_LD  = SRST_CYC[7:0] - 8'h01;

  reg       busy_q;  // soft reset in progress
  reg [7:0] cnt_q;   // cycles left

  // ==========================================================
  // timed soft reset; a restart while busy is ignored
  always @(posedge ref_clk_in) begin
    if (reset_in) begin
      busy_q <= 1'b0;
      cnt_q  <= 8'h00;
    end else if (busy_q) begin
      // self clearing once the count runs out
      if (cnt_q == 8'h00) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 8'h01;
      end
    end else if (start_in) begin
      busy_q <= 1'b1;
      cnt_q  <= SRST_LD;
    end
  end

  assign busy_out = busy_q;

endmodule // pmr_soft_reset

`default_nettype wire

// ===== tb/pmr_mgmt_master.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmr_map.vh"
// ==================================================
// station model: drives mdc and its side of mdio
module pmr_mgmt_master (
  // clock
  input  wire logic ref_clk_in,
  // serial pins
  output var  logic mdc_out,
  output var  logic mdio_out,
  output var  logic mdio_oe_n_out,
  input  wire logic mdio_in
);
  // mdc rests low between frames, data left to the pull-up
  initial begin
    mdc_out = 1'b0;
    mdio_out = 1'b1;
    mdio_oe_n_out = 1'b1;
  end
  // ==================================================
  // one frame, msb first; half is the mdc half period in ref clocks
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, input int half, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      @(posedge ref_clk_in);
      mdc_out <= 1'b0;
      mdio_out <= bits[63-i];
      // let go from the turnaround on reads
      mdio_oe_n_out <= (op == `PMR_OP_RD) && (i >= 46);
      repeat (half) @(posedge ref_clk_in);
      // data launched on the previous rising edge
      if (i >= 48)
        rd[63-i] = mdio_in;
      mdc_out <= 1'b1;
      repeat (half - 1) @(posedge ref_clk_in);
    end
    @(posedge ref_clk_in);
    mdc_out <= 1'b0;
    mdio_oe_n_out <= 1'b1;
    // gap so a write lands before the next preamble
    repeat (12) @(posedge ref_clk_in);
  endtask
endmodule // pmr_mgmt_master
`default_nettype wire

// ===== tb/pmr_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmr_map.vh"
// ==================================================
// port checker for the phy register set
module pmr_checker (
  // clock and reset
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  // serial pins
  input wire logic        mdc_in,
  input wire logic        mdio_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe_n_out,
  // phy state
  input wire logic        negotiation_done_in,
  input wire logic        far_fault_in,
  input wire logic        link_up_in,
  input wire logic [15:0] partner_ability_in,
  // controls
  input wire logic        soft_reset_out,
  input wire logic        negotiation_on_out,
  input wire logic        full_duplex_out,
  input wire logic        crossover_algorithm_select_out,
  input wire logic        force_mdi_out,
  input wire logic        auto_mdix_off_out,
  input wire logic        far_fault_off_out,
  input wire logic        tx_off_out,
  input wire logic        led_off_out,
  input wire logic        adv_pause_out,
  input wire logic [3:0]  adv_ability_out
);
  localparam int          SRST_N = `PMR_SRST_CYCLES; // soft reset length
  localparam logic [12:0] DFLT   = 13'h1C1F;         // control and advert defaults
  wire  [12:0] ctl;    // control pins gathered
  logic [5:0]  srst_q; // cycles soft reset has stood
  logic [5:0]  idle_q; // cycles since mdc moved
  logic        mdc_q;  // mdc one cycle back
  assign ctl = {negotiation_on_out, full_duplex_out, crossover_algorithm_select_out,
                force_mdi_out, auto_mdix_off_out, far_fault_off_out, tx_off_out,
                led_off_out, adv_pause_out, adv_ability_out};
  // ==================================================
  // helper counters
  always @(posedge ref_clk_in) begin
    mdc_q <= mdc_in;
    if (reset_in || !soft_reset_out)
      srst_q <= 6'h00;
    else
      srst_q <= srst_q + 6'h01;
    // quiet time tells a finished frame from one in flight
    if (reset_in || mdc_in != mdc_q)
      idle_q <= 6'h00;
    else if (idle_q != 6'h3F)
      idle_q <= idle_q + 6'h01;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // ==================================================
  // assertions
  property p_rst_dflt;
    $fell(reset_in) |-> ctl == DFLT && mdio_oe_n_out && !soft_reset_out;
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) else $error("bad reset values");
  property p_srst_len;
    $fell(soft_reset_out) |-> srst_q == SRST_N;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length");
  property p_srst_max;
    soft_reset_out |-> srst_q < SRST_N;
  endproperty
  a_srst_max: assert property (p_srst_max) else $error("soft reset too long");
  property p_srst_dflt;
    $fell(soft_reset_out) |-> ctl == DFLT;
  endproperty
  a_srst_dflt: assert property (p_srst_dflt) else $error("soft reset values");
  property p_ta_zero;
    $fell(mdio_oe_n_out) |-> (!mdio_out && !mdio_oe_n_out) [*8];
  endproperty
  a_ta_zero: assert property (p_ta_zero) else $error("turnaround not zero");
  property p_read_still;
    !mdio_oe_n_out |-> $stable(ctl);
  endproperty
  a_read_still: assert property (p_read_still) else $error("control moved on read");
  property p_quiet;
    idle_q >= 6'd12 && !soft_reset_out && !$past(soft_reset_out) |-> $stable(ctl);
  endproperty
  a_quiet: assert property (p_quiet) else $error("control moved while idle");
  property p_release;
    idle_q >= 6'd12 |-> mdio_oe_n_out;
  endproperty
  a_release: assert property (p_release) else $error("pin held while idle");
  // main scenarios reached
  c_read: cover property ($fell(mdio_oe_n_out));
  c_srst: cover property ($fell(soft_reset_out));
  c_txoff: cover property ($rose(tx_off_out));
endmodule // pmr_checker
bind pmr_phy_regs pmr_checker pmr_checker_i (
  .ref_clk_in, .reset_in, .mdc_in, .mdio_in, .mdio_out, .mdio_oe_n_out, .negotiation_done_in,
  .far_fault_in, .link_up_in, .partner_ability_in, .soft_reset_out, .negotiation_on_out,
  .full_duplex_out, .crossover_algorithm_select_out, .force_mdi_out, .auto_mdix_off_out,
  .far_fault_off_out, .tx_off_out, .led_off_out, .adv_pause_out, .adv_ability_out);
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "pmr_map.vh"
// ==================================================
// bench: station model against the register set
module tb_top;
  localparam logic [4:0]  PA  = 5'h01;    // port under test
  localparam logic [15:0] IDH = 16'h0A5C; // arbitrary value
  localparam logic [15:0] IDL = 16'h3C96; // arbitrary value
  logic        clk = 1'b0;     // 25 MHz
  logic        rst = 1'b1;     // held 8 cycles
  logic        an_done = 1'b0; // phy state
  logic        fault = 1'b0;
  logic        link = 1'b0;
  logic [15:0] part = 16'h0000;
  logic [4:0]  pa_v = PA;      // address of next frame
  int          half_v = 5;     // mdc half period
  int          bad_count = 0;
  int          n_tests = 0;
  int          srst_n = 0;     // soft reset cycles seen
  wire         mdc, m_dat, m_oe_n, d_dat, d_oe_n, srst;
  wire         mdio_w;         // resolved wire
  wire  [12:0] ctl;            // control and advert pins
  // pull-up wins when nobody drives
  assign mdio_w = !d_oe_n ? d_dat : !m_oe_n ? m_dat : 1'b1;
  always #20 clk = ~clk;
  always @(posedge clk) if (srst === 1'b1) srst_n++;
  pmr_phy_regs #(.PHY_ADDR(PA), .ID_HI(IDH), .ID_LO(IDL)) pmr_phy_regs_i (
    .ref_clk_in(clk), .reset_in(rst), .mdc_in(mdc), .mdio_in(mdio_w),
    .mdio_out(d_dat), .mdio_oe_n_out(d_oe_n), .negotiation_done_in(an_done),
    .far_fault_in(fault), .link_up_in(link), .partner_ability_in(part),
    .soft_reset_out(srst), .negotiation_on_out(ctl[12]), .full_duplex_out(ctl[11]),
    .crossover_algorithm_select_out(ctl[10]), .force_mdi_out(ctl[9]),
    .auto_mdix_off_out(ctl[8]), .far_fault_off_out(ctl[7]), .tx_off_out(ctl[6]),
    .led_off_out(ctl[5]), .adv_pause_out(ctl[4]), .adv_ability_out(ctl[3:0]));
  pmr_mgmt_master pmr_mgmt_master_i (
    .ref_clk_in(clk), .mdc_out(mdc), .mdio_out(m_dat), .mdio_oe_n_out(m_oe_n),
    .mdio_in(mdio_w));
  // ==================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] rd;
    pmr_mgmt_master_i.frame(`PMR_OP_WR, pa_v, ra, wd, half_v, rd);
  endtask
  task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp, input string what);
    logic [15:0] rd;
    pmr_mgmt_master_i.frame(`PMR_OP_RD, pa_v, ra, 16'h0000, half_v, rd);
    check(what, rd, exp);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==================================================
  // scenarios
  task automatic t_dflt();
    rdchk(`PMR_REG_CTRL, 16'h1120, "ctrl");
    rdchk(`PMR_REG_STAT, 16'h7808, "stat");
    rdchk(`PMR_REG_ID_HI, IDH, "id hi");
    rdchk(`PMR_REG_ID_LO, IDL, "id lo");
    rdchk(`PMR_REG_ADV, 16'h0DE1, "adv");
    check("pins", {3'h0, ctl}, 16'h1C1F);
  endtask
  task automatic t_ctrl();
    wr(`PMR_REG_CTRL, 16'h7EDF);
    rdchk(`PMR_REG_CTRL, 16'h101F, "ctrl set");
    check("pins set", {3'h0, ctl}, 16'h13FF);
    wr(`PMR_REG_CTRL, 16'h0000);
    rdchk(`PMR_REG_CTRL, 16'h0000, "ctrl clr");
    check("pins clr", {3'h0, ctl}, 16'h001F);
  endtask
  task automatic t_stat();
    an_done <= 1'b1;
    fault <= 1'b1;
    link <= 1'b1;
    rdchk(`PMR_REG_STAT, 16'h783C, "stat up");
    wr(`PMR_REG_CTRL, 16'h0004);
    wr(`PMR_REG_STAT, 16'h0000);
    rdchk(`PMR_REG_STAT, 16'h782C, "stat mask");
    an_done <= 1'b0;
    link <= 1'b0;
    rdchk(`PMR_REG_STAT, 16'h7808, "stat down");
  endtask
  task automatic t_adv();
    wr(`PMR_REG_ADV, 16'h0000);
    rdchk(`PMR_REG_ADV, 16'h0801, "adv clr");
    check("adv pins clr", {3'h0, ctl}, 16'h0080);
    wr(`PMR_REG_ADV, 16'hFFFF);
    rdchk(`PMR_REG_ADV, 16'h0FE1, "adv set");
    check("adv pins set", {3'h0, ctl}, 16'h009F);
  endtask
  // refused frames leave the wire to the pull-up
  task automatic t_refuse();
    logic [15:0] rd;
    part <= 16'hFFFF;
    half_v = 8;
    rdchk(`PMR_REG_PART, 16'h05E1, "partner");
    half_v = 5;
    rdchk(`PMR_REG_CDIAG, 16'h0000, "diag");
    rdchk(`PMR_REG_SPEC, 16'h0000, "special");
    rdchk(5'h06, 16'hFFFF, "unmapped");
    wr(`PMR_REG_ID_HI, 16'h0000);
    rdchk(`PMR_REG_ID_HI, IDH, "id kept");
    // undefined opcode must not commit
    pmr_mgmt_master_i.frame(2'b11, pa_v, `PMR_REG_CTRL, 16'h0003, half_v, rd);
    pa_v = 5'h02;
    wr(`PMR_REG_CTRL, 16'h0003);
    rdchk(`PMR_REG_CTRL, 16'hFFFF, "other port");
    pa_v = PA;
    check("pins kept", {3'h0, ctl}, 16'h009F);
  endtask
  // soft reset, then a hard reset in mid-run
  task automatic t_soft();
    srst_n = 0;
    wr(`PMR_REG_CTRL, 16'h8003);
    repeat (40) @(posedge clk);
    check("srst len", 16'(srst_n), 16'(`PMR_SRST_CYCLES));
    rdchk(`PMR_REG_CTRL, 16'h1120, "ctrl srst");
    check("pins srst", {3'h0, ctl}, 16'h1C1F);
    wr(`PMR_REG_CTRL, 16'h0003);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    check("pins rst", {3'h0, ctl}, 16'h1C1F);
  endtask
  // ==================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_dflt();
    t_ctrl();
    t_stat();
    t_adv();
    t_refuse();
    t_soft();
    conclude();
  end
  // about 30 frames of some 650 cycles each, with margin
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
